/* hdl/epd_frame_ctrl.sv */
// Purpose: command decoder, plane loading, data stop and refresh of the panel controller
// Assumes: classic wishbone slave, rst_i is the hardware reset pin of the device
// Notes: both planes live here as byte arrays; refresh time is a parameter
//
// Decided for this implementation: the register offsets and the Wishbone slave port.
`timescale 1ns/10ps
module epd_frame_ctrl #(
   parameter int REFRESH_CYCLES = epd_pkg::REFRESH_CYCLES
) (
   input logic clk_i,
   input logic rst_i,
   input logic sclk_i,
   input logic cs_n_i,
   input logic dc_i,
   input logic sda_i,
   output logic sda_o,
   output logic sda_oe_n_o,
   output logic busy_n_o,
   output logic src_drive_o,
   output logic vcom_drive_o,
   input logic wb_cyc_i,
   input logic wb_stb_i,
   input logic wb_we_i,
   input logic [4:0] wb_adr_i,
   input logic [3:0] wb_sel_i,
   input logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic irq_o
);
   epd_pkg::epd_rx_s rx;
   epd_pkg::epd_state_e st_q, st_d;
   logic [7:0] plane_a [epd_pkg::PLANE_DEPTH];
   logic [7:0] plane_b [epd_pkg::PLANE_DEPTH];
   logic [7:0] prm_q [8];
   logic [2:0] pidx_q, pidx_d;
   logic plane_q, plane_d, win_q, win_d;
   logic got1_q, got1_d, got2_q, got2_d;
   logic [epd_pkg::AW-1:0] addr_q, addr_d, rbase_q, rbase_d;
   logic [5:0] col_q, col_d, cols_q, cols_d;
   logic [8:0] rows_q, rows_d;
   logic [epd_pkg::CNT_W-1:0] cnt_q, cnt_d;
   logic busy_n_q, busy_n_d, drv_q, drv_d;
   logic tx_load_q, tx_load_d;
   logic [7:0] tx_byte_q, tx_byte_d;
   logic mem_we, start, done_ev;
   logic [epd_pkg::IRQ_W-1:0] ev;
   logic flag;

   function automatic logic [8:0] prm9(input logic [7:0] hi, input logic [7:0] lo);
      prm9 = {hi[0], lo};
   endfunction

   epd_serial_rx u_rx (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .sclk_i(sclk_i),
      .cs_n_i(cs_n_i),
      .dc_i(dc_i),
      .sda_i(sda_i),
      .tx_load_i(tx_load_q),
      .tx_byte_i(tx_byte_q),
      .rx_o(rx),
      .sda_o(sda_o),
      .sda_oe_n_o(sda_oe_n_o)
   );

   assign flag = got1_q & got2_q;

   // command and load sequencing
   always_comb begin
      logic [8:0] x9, y9, w9, l9;
      x9 = '0;
      y9 = '0;
      w9 = '0;
      l9 = '0;
      st_d = st_q;
      pidx_d = pidx_q;
      plane_d = plane_q;
      win_d = win_q;
      got1_d = got1_q;
      got2_d = got2_q;
      addr_d = addr_q;
      rbase_d = rbase_q;
      col_d = col_q;
      cols_d = cols_q;
      rows_d = rows_q;
      tx_load_d = 1'b0;
      tx_byte_d = tx_byte_q;
      mem_we = 1'b0;
      start = 1'b0;
      ev = '0;
      if (rx.valid && st_q != epd_pkg::ST_SLEEP) begin
         if (!rx.is_data) begin
            st_d = epd_pkg::ST_IDLE;
            case (rx.data)
               epd_pkg::CMD_SLEEP: st_d = epd_pkg::ST_SLEEP_CHK;
               epd_pkg::CMD_LOAD1, epd_pkg::CMD_LOAD2: begin
                  st_d = epd_pkg::ST_LOAD;
                  plane_d = (rx.data == epd_pkg::CMD_LOAD2);
                  win_d = 1'b0;
                  addr_d = '0;
               end
               epd_pkg::CMD_WIN1, epd_pkg::CMD_WIN2: begin
                  st_d = epd_pkg::ST_WIN_PRM;
                  plane_d = (rx.data == epd_pkg::CMD_WIN2);
                  pidx_d = '0;
               end
               epd_pkg::CMD_STOP: begin
                  if (busy_n_q) begin
                     tx_load_d = 1'b1;
                     tx_byte_d = '0;
                     tx_byte_d[epd_pkg::FLAG_BIT] = flag;
                     start = flag;
                  end
               end
               epd_pkg::CMD_REFRESH: start = busy_n_q;
               default: st_d = epd_pkg::ST_IDLE;
            endcase
            if (st_d == epd_pkg::ST_LOAD || st_d == epd_pkg::ST_WIN_PRM) begin
               if (plane_d) got2_d = 1'b0;
               else got1_d = 1'b0;
            end
         end else begin
            case (st_q)
               epd_pkg::ST_SLEEP_CHK: begin
                  if (rx.data == epd_pkg::SLEEP_CODE) begin
                     st_d = epd_pkg::ST_SLEEP;
                     ev[epd_pkg::EV_SLEEP] = 1'b1;
                  end else begin
                     st_d = epd_pkg::ST_IDLE;
                     ev[epd_pkg::EV_BADCODE] = 1'b1;
                  end
               end
               epd_pkg::ST_WIN_PRM: begin
                  pidx_d = pidx_q + 3'h1;
                  if (pidx_q == epd_pkg::PRM_LAST) begin
                     x9 = prm9(prm_q[0], prm_q[1]);
                     y9 = prm9(prm_q[2], prm_q[3]);
                     // the low byte of L arrives with this very byte
                     l9 = prm9(prm_q[6], rx.data);
                     w9 = prm9(prm_q[4], prm_q[5]);
                     // three low bits of X and W are dropped
                     rbase_d = 13'(y9) * epd_pkg::ROW_BYTES + 13'(x9[8:3]);
                     addr_d = rbase_d;
                     cols_d = w9[8:3];
                     col_d = '0;
                     rows_d = l9;
                     win_d = 1'b1;
                     st_d = (cols_d == '0 || l9 == '0) ? epd_pkg::ST_IDLE : epd_pkg::ST_LOAD;
                  end
               end
               epd_pkg::ST_LOAD: begin
                  mem_we = (addr_q < epd_pkg::PLANE_BYTES);
                  addr_d = addr_q + 13'h1;
                  if (win_q) begin
                     col_d = col_q + 6'h1;
                     if (col_d == cols_q) begin
                        col_d = '0;
                        rows_d = rows_q - 9'h1;
                        rbase_d = rbase_q + epd_pkg::ROW_BYTES;
                        addr_d = rbase_d;
                     end
                  end
                  if ((!win_q && addr_d == epd_pkg::PLANE_BYTES) || (win_q && rows_d == '0)) begin
                     st_d = epd_pkg::ST_IDLE;
                     if (plane_q) got2_d = 1'b1;
                     else got1_d = 1'b1;
                     // plane one closing a frame starts refresh itself
                     if (!plane_q && got2_q && busy_n_q) start = 1'b1;
                  end
               end
               default: st_d = st_q;
            endcase
         end
      end
      if (got1_d && got2_d && !(got1_q && got2_q)) ev[epd_pkg::EV_FRAME] = 1'b1;
      if (start) begin
         got1_d = 1'b0;
         got2_d = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q <= epd_pkg::ST_IDLE;
         pidx_q <= '0;
         plane_q <= 1'b0;
         win_q <= 1'b0;
         got1_q <= 1'b0;
         got2_q <= 1'b0;
         addr_q <= '0;
         rbase_q <= '0;
         col_q <= '0;
         cols_q <= '0;
         rows_q <= '0;
         tx_load_q <= 1'b0;
         tx_byte_q <= '0;
      end else begin
         st_q <= st_d;
         pidx_q <= pidx_d;
         plane_q <= plane_d;
         win_q <= win_d;
         got1_q <= got1_d;
         got2_q <= got2_d;
         addr_q <= addr_d;
         rbase_q <= rbase_d;
         col_q <= col_d;
         cols_q <= cols_d;
         rows_q <= rows_d;
         tx_load_q <= tx_load_d;
         tx_byte_q <= tx_byte_d;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rx.valid && rx.is_data && st_q == epd_pkg::ST_WIN_PRM) begin
         prm_q[pidx_q] <= rx.data;
      end
      if (mem_we && !plane_q) begin
         plane_a[addr_q] <= rx.data;
      end
      if (mem_we && plane_q) begin
         plane_b[addr_q] <= rx.data;
      end
   end

   // refresh timing and busy
   always_comb begin
      cnt_d = cnt_q;
      if (start) cnt_d = epd_pkg::CNT_W'(REFRESH_CYCLES);
      else if (cnt_q != '0) cnt_d = cnt_q - 1'b1;
      busy_n_d = (cnt_d == '0);
      drv_d = (cnt_d != '0);
      done_ev = (cnt_q != '0) && (cnt_d == '0);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_q <= '0;
         busy_n_q <= 1'b1;
         drv_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         busy_n_q <= busy_n_d;
         drv_q <= drv_d;
      end
   end

   assign busy_n_o = busy_n_q;
   assign src_drive_o = drv_q;
   assign vcom_drive_o = drv_q;

   // wishbone slave and interrupt
   logic [3:0] ctrl_q, ctrl_d;
   logic [epd_pkg::IRQ_W-1:0] ist_q, ist_d, imask_q, imask_d;
   logic [13:0] paddr_q, paddr_d;
   logic [7:0] pdat_q;
   logic [31:0] dat_q, dat_d;
   logic ack_q, ack_d, irq_q, irq_d, wr;

   always_comb begin
      ack_d = wb_cyc_i && wb_stb_i && !ack_q;
      wr = ack_d && wb_we_i && wb_sel_i[0];
      ctrl_d = ctrl_q;
      imask_d = imask_q;
      paddr_d = paddr_q;
      ist_d = ist_q;
      dat_d = '0;
      if (wr && wb_adr_i == epd_pkg::REG_CTRL) ctrl_d = wb_dat_i[3:0];
      if (wr && wb_adr_i == epd_pkg::REG_IRQ_MASK) imask_d = wb_dat_i[epd_pkg::IRQ_W-1:0];
      if (wr && wb_adr_i == epd_pkg::REG_IRQ_STAT) ist_d = ist_q & ~wb_dat_i[epd_pkg::IRQ_W-1:0];
      if (ack_d && wb_we_i && wb_adr_i == epd_pkg::REG_PIX_ADDR) begin
         if (wb_sel_i[0]) paddr_d[7:0] = wb_dat_i[7:0];
         if (wb_sel_i[1]) paddr_d[13:8] = wb_dat_i[13:8];
      end
      // a new event wins over a clear in the same cycle
      ist_d = ist_d | ev;
      ist_d[epd_pkg::EV_DONE] = ist_d[epd_pkg::EV_DONE] | done_ev;
      irq_d = |(ist_d & imask_d);
      if (ack_d && !wb_we_i) begin
         case (wb_adr_i)
            epd_pkg::REG_CTRL: dat_d[3:0] = ctrl_q;
            epd_pkg::REG_STATUS: dat_d[7:0] = {flag, got2_q, got1_q, ~busy_n_q,
                                               (st_q == epd_pkg::ST_SLEEP), st_q};
            epd_pkg::REG_IRQ_STAT: dat_d[epd_pkg::IRQ_W-1:0] = ist_q;
            epd_pkg::REG_IRQ_MASK: dat_d[epd_pkg::IRQ_W-1:0] = imask_q;
            epd_pkg::REG_PIX_ADDR: dat_d[13:0] = paddr_q;
            epd_pkg::REG_PIX_DATA: dat_d[7:0] = pdat_q;
            default: dat_d = '0;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      pdat_q <= paddr_q[13] ? plane_b[paddr_q[epd_pkg::AW-1:0]] : plane_a[paddr_q[epd_pkg::AW-1:0]];
      if (rst_i) begin
         ctrl_q <= epd_pkg::CTRL_RESET;
         imask_q <= '0;
         ist_q <= '0;
         paddr_q <= '0;
         dat_q <= '0;
         ack_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         imask_q <= imask_d;
         ist_q <= ist_d;
         paddr_q <= paddr_d;
         dat_q <= dat_d;
         ack_q <= ack_d;
         irq_q <= irq_d;
      end
   end

   assign wb_dat_o = dat_q;
   assign wb_ack_o = ack_q;
   assign irq_o = irq_q;

   localparam int RC = REFRESH_CYCLES;
   logic rxd, rxc;
   assign rxd = rx.valid && rx.is_data;
   assign rxc = rx.valid && !rx.is_data && st_q != epd_pkg::ST_SLEEP;

   chk_sleep_bad: assert property (@(posedge clk_i) disable iff (rst_i)
      rxd && st_q == epd_pkg::ST_SLEEP_CHK && rx.data != epd_pkg::SLEEP_CODE
      |=> st_q == epd_pkg::ST_IDLE) else $error("sleep entered on bad code");
   chk_sleep_enter: assert property (@(posedge clk_i) disable iff (rst_i)
      rxd && st_q == epd_pkg::ST_SLEEP_CHK && rx.data == epd_pkg::SLEEP_CODE
      |=> st_q == epd_pkg::ST_SLEEP) else $error("sleep not entered");
   chk_sleep_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      st_q == epd_pkg::ST_SLEEP |=> st_q == epd_pkg::ST_SLEEP && $stable(busy_n_q))
      else $error("left sleep without reset");
   chk_plane_a: assert property (@(posedge clk_i) disable iff (rst_i)
      mem_we && !plane_q |=> plane_a[$past(addr_q)] == $past(rx.data))
      else $error("plane one byte not stored");
   chk_plane_b: assert property (@(posedge clk_i) disable iff (rst_i)
      mem_we && plane_q |=> plane_b[$past(addr_q)] == $past(rx.data))
      else $error("plane two byte not stored");
   chk_win_base: assert property (@(posedge clk_i) disable iff (rst_i)
      rxd && st_q == epd_pkg::ST_WIN_PRM && pidx_q == epd_pkg::PRM_LAST
      |=> addr_q == 13'(prm9(prm_q[2], prm_q[3])) * epd_pkg::ROW_BYTES
          + 13'(prm_q[1][7:3]) + 13'(prm_q[0][0]) * 13'h0020)
      else $error("window start address wrong");
   chk_stop_status: assert property (@(posedge clk_i) disable iff (rst_i)
      rxc && rx.data == epd_pkg::CMD_STOP && busy_n_q
      |=> tx_load_q && tx_byte_q == {$past(flag), 7'h00}) else $error("bad stop status");
   chk_stop_busy: assert property (@(posedge clk_i) disable iff (rst_i)
      rxc && rx.data == epd_pkg::CMD_STOP && !busy_n_q |=> !tx_load_q && !busy_n_q)
      else $error("stop acted while busy");
   chk_refresh_go: assert property (@(posedge clk_i) disable iff (rst_i)
      rxc && rx.data == epd_pkg::CMD_REFRESH && busy_n_q |=> !busy_n_q ##1 !busy_n_q)
      else $error("refresh not started");
   chk_busy_len: assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(busy_n_q) |-> cnt_q == epd_pkg::CNT_W'(RC) && drv_q)
      else $error("busy low without full refresh count");
   cov_sleep: cover property (@(posedge clk_i) st_q == epd_pkg::ST_SLEEP);
   cov_refresh: cover property (@(posedge clk_i) $rose(busy_n_q));
   cov_frame: cover property (@(posedge clk_i) ev[epd_pkg::EV_FRAME]);
endmodule

/* hdl/epd_pkg.sv */
// Purpose: constants, types and states of the e-paper frame load and refresh block
// Assumes: 250 MHz core clock, serial link sampled by that clock
// Notes: Wishbone word offsets below are byte addresses
//
// What this block does
// - sleep command takes one check byte; only 0xa5 makes it execute.
// - valid sleep command puts the device into deep sleep.
// - only hardware reset leaves deep sleep; host wakes it by reset pin.
// - first full transfer fills old-data plane (b/w) or b/w plane (b/w/red).
// - second full transfer fills new-data plane (b/w) or red plane (b/w/red).
// - partial transfers fill the same planes, limited to their window.
// - partial transfers take X, Y, W, L as high byte then low byte first.
// - status byte bit 7 is the frame-complete flag, both planes received.
// - transfer or stop with frame complete pulls busy low, refresh starts; here a plane-two transfer that completes the frame does not.
// - after complete, stopped transfer the panel drive waveforms start.
// - data-stop acts only while busy is high; host waits for that.
// - refresh command refreshes from the planes and pulls busy low.
// - refresh command accepted only while busy is high.
// - busy falls when a long operation begins, rises when it ends.
package epd_pkg;
   localparam logic [7:0] CMD_SLEEP = 8'h07;
   localparam logic [7:0] CMD_LOAD1 = 8'h10;
   localparam logic [7:0] CMD_STOP = 8'h11;
   localparam logic [7:0] CMD_REFRESH = 8'h12;
   localparam logic [7:0] CMD_LOAD2 = 8'h13;
   localparam logic [7:0] CMD_WIN1 = 8'h14;
   localparam logic [7:0] CMD_WIN2 = 8'h15;
   localparam logic [7:0] SLEEP_CODE = 8'ha5;
   localparam int FLAG_BIT = 7;
   localparam int AW = 13;
   localparam logic [AW-1:0] ROW_BYTES = 13'h0016;
   localparam logic [AW-1:0] PLANE_BYTES = 13'h16b0;
   localparam int PLANE_DEPTH = 5808;
   localparam logic [2:0] PRM_LAST = 3'h7;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam int CLK_MHZ = 250;
   localparam int REFRESH_US = 2000;
   localparam int REFRESH_CYCLES = REFRESH_US * CLK_MHZ;
   localparam int CNT_W = 20;
   // wishbone byte offsets
   localparam logic [4:0] REG_CTRL = 5'h00;
   localparam logic [4:0] REG_STATUS = 5'h04;
   localparam logic [4:0] REG_IRQ_STAT = 5'h08;
   localparam logic [4:0] REG_IRQ_MASK = 5'h0c;
   localparam logic [4:0] REG_PIX_ADDR = 5'h10;
   localparam logic [4:0] REG_PIX_DATA = 5'h14;
   localparam logic [3:0] CTRL_RESET = 4'h0;
   // interrupt bits
   localparam int IRQ_W = 4;
   localparam int EV_FRAME = 0;
   localparam int EV_DONE = 1;
   localparam int EV_SLEEP = 2;
   localparam int EV_BADCODE = 3;
   // synchroniser lanes
   localparam int LN_SCLK = 3;
   localparam int LN_CS = 2;
   localparam int LN_DC = 1;
   localparam int LN_SDA = 0;

   typedef struct packed {
      logic valid;
      logic is_data;
      logic [7:0] data;
   } epd_rx_s;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_SLEEP_CHK = 3'b001,
      ST_LOAD = 3'b010,
      ST_WIN_PRM = 3'b011,
      ST_SLEEP = 3'b100
   } epd_state_e;
endpackage

/* hdl/epd_serial_rx.sv */
// Purpose: serial byte receiver and status byte sender of the command port
// Assumes: link pins are asynchronous to clk_i
// Notes: bits are taken msb first on the serial clock rising edge
`timescale 1ns/10ps
module epd_serial_rx (
   input logic clk_i,
   input logic rst_i,
   input logic sclk_i,
   input logic cs_n_i,
   input logic dc_i,
   input logic sda_i,
   input logic tx_load_i,
   input logic [7:0] tx_byte_i,
   output epd_pkg::epd_rx_s rx_o,
   output logic sda_o,
   output logic sda_oe_n_o
);
   logic [3:0] s1_q, s2_q, s3_q, filt_q, filt_d;
   logic [2:0] cnt_q, cnt_d, tcnt_q, tcnt_d;
   logic [7:0] sh_q, sh_d, tsh_q, tsh_d;
   logic tact_q, tact_d, sda_q, sda_d, oen_q, oen_d;
   epd_pkg::epd_rx_s rx_q, rx_d;
   logic rise, fall;

   always_comb begin
      // a lane changes once the second and third stages agree
      filt_d = (s2_q & s3_q) | (filt_q & (s2_q ^ s3_q));
      rise = filt_d[epd_pkg::LN_SCLK] & ~filt_q[epd_pkg::LN_SCLK];
      fall = ~filt_d[epd_pkg::LN_SCLK] & filt_q[epd_pkg::LN_SCLK];
      cnt_d = cnt_q;
      sh_d = sh_q;
      tcnt_d = tcnt_q;
      tsh_d = tsh_q;
      tact_d = tact_q;
      sda_d = sda_q;
      oen_d = oen_q;
      rx_d = '0;
      if (filt_d[epd_pkg::LN_CS]) begin
         cnt_d = '0;
         tcnt_d = '0;
         tact_d = 1'b0;
         oen_d = 1'b1;
      end else if (tx_load_i) begin
         tact_d = 1'b1;
         tsh_d = tx_byte_i;
         sda_d = tx_byte_i[7];
         oen_d = 1'b0;
         tcnt_d = '0;
      end else if (tact_q) begin
         if (rise) begin
            tcnt_d = tcnt_q + 3'h1;
            if (tcnt_q == epd_pkg::BIT_LAST) begin
               tact_d = 1'b0;
               oen_d = 1'b1;
            end
         end else if (fall && tcnt_q != '0) begin
            // the fall that closes the command byte must not shift out bit 7
            tsh_d = {tsh_q[6:0], 1'b0};
            sda_d = tsh_q[6];
         end
      end else if (rise) begin
         sh_d = {sh_q[6:0], filt_d[epd_pkg::LN_SDA]};
         cnt_d = cnt_q + 3'h1;
         if (cnt_q == epd_pkg::BIT_LAST) begin
            rx_d.valid = 1'b1;
            rx_d.is_data = filt_d[epd_pkg::LN_DC];
            rx_d.data = {sh_q[6:0], filt_d[epd_pkg::LN_SDA]};
         end
      end
   end

   always_ff @(posedge clk_i) begin
      s1_q <= {sclk_i, cs_n_i, dc_i, sda_i};
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (rst_i) begin
         filt_q <= 4'h4;
         cnt_q <= '0;
         sh_q <= '0;
         tcnt_q <= '0;
         tsh_q <= '0;
         tact_q <= 1'b0;
         sda_q <= 1'b0;
         oen_q <= 1'b1;
         rx_q <= '0;
      end else begin
         filt_q <= filt_d;
         cnt_q <= cnt_d;
         sh_q <= sh_d;
         tcnt_q <= tcnt_d;
         tsh_q <= tsh_d;
         tact_q <= tact_d;
         sda_q <= sda_d;
         oen_q <= oen_d;
         rx_q <= rx_d;
      end
   end

   assign rx_o = rx_q;
   assign sda_o = sda_q;
   assign sda_oe_n_o = oen_q;
endmodule

/* verification/epd_host_model.sv */
// Purpose: host side of the serial command port
// Assumes: bench clock of 4 ns; link clock of 84 ns made from it
// Notes: link clock stands low while deselected; a released data line toggles
`timescale 1ns/10ps
module epd_host_model (
   input wire logic clk_i,
   input wire logic pin_i,
   output logic sclk_o,
   output logic cs_n_o,
   output logic dc_o,
   output logic sda_o
);
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      dc_o = 1'b0;
      sda_o = 1'b0;
   end

   // one bit: data set while the link clock is low, pin taken at its rise
   task automatic slot(input logic b, output logic s);
      @(posedge clk_i);
      sclk_o <= 1'b0;
      sda_o <= b;
      repeat (10) @(posedge clk_i);
      sclk_o <= 1'b1;
      s = pin_i;
      repeat (10) @(posedge clk_i);
   endtask

   // commands go with dc low, parameters and pixels with dc high
   task automatic send(input logic is_data, input logic [7:0] b);
      logic s;
      @(posedge clk_i);
      cs_n_o <= 1'b0;
      dc_o <= is_data;
      for (int i = 7; i >= 0; i--) begin
         slot(b[i], s);
      end
   endtask

   // status read after the stop command, line released meanwhile
   task automatic read(output logic [7:0] q);
      for (int i = 7; i >= 0; i--) begin
         slot(~sda_o, q[i]);
      end
   endtask

   task automatic desel;
      @(posedge clk_i);
      cs_n_o <= 1'b1;
      sclk_o <= 1'b0;
      repeat (10) @(posedge clk_i);
   endtask
endmodule

/* verification/test_epaper_frame_load_refresh.sv */
// Purpose: self-checking bench of the frame load and refresh block
// Assumes: refresh time shortened to 400 cycles
// Notes: planes are closed by small windows, which count as received planes
`timescale 1ns/10ps
module test_epaper_frame_load_refresh;
   logic clk_i, rst_i, cyc, we, ack, irq, busy_n, src, vcom, sda_o, oe_n, oe_seen;
   logic sclk, cs_n, dc, hsda, pin;
   logic [4:0] adr;
   logic [31:0] wdat, rdat, q;
   logic [7:0] s;
   int miscompares = 0;
   int cmp_count = 0;
   assign pin = oe_n ? hsda : sda_o;

   epd_frame_ctrl #(.REFRESH_CYCLES(400)) DUT (.clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk),
      .cs_n_i(cs_n), .dc_i(dc), .sda_i(pin), .sda_o(sda_o), .sda_oe_n_o(oe_n),
      .busy_n_o(busy_n), .src_drive_o(src), .vcom_drive_o(vcom), .wb_cyc_i(cyc),
      .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq));
   epd_host_model host (.clk_i(clk_i), .pin_i(pin), .sclk_o(sclk), .cs_n_o(cs_n),
      .dc_o(dc), .sda_o(hsda));

   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   always @(posedge clk_i) if (oe_n === 1'b0) oe_seen <= 1'b1;

   task automatic finish_test;
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic tmo;
      miscompares++;
      finish_test;
   endtask

   task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk_i);
         n++;
         if (n > 50) tmo;
      end while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
   endtask

   task automatic pix(input logic [13:0] a, input logic [7:0] b);
      wb(1'b1, epd_pkg::REG_PIX_ADDR, {18'h0, a});
      wb(1'b0, epd_pkg::REG_PIX_DATA, 32'h0);
      check("pixel byte", q & 32'hff, {24'h0, b});
   endtask

   task automatic win(input logic [7:0] c, input logic [63:0] p, input logic [15:0] px);
      host.send(1'b0, c);
      for (int i = 7; i >= 0; i--) host.send(1'b1, p[i*8+:8]);
      host.send(1'b1, px[15:8]);
      host.send(1'b1, px[7:0]);
      host.desel();
   endtask

   task automatic t_reset;
      check("busy idle", {31'h0, busy_n}, 32'h1);
      check("sda released", {31'h0, oe_n}, 32'h1);
      check("irq idle", {31'h0, irq}, 32'h0);
      wb(1'b0, 5'h1c, 32'h0);
      check("unmapped", q, 32'h0);
   endtask

   task automatic t_sleep;
      host.send(1'b0, epd_pkg::CMD_SLEEP);
      host.send(1'b1, 8'h3c);
      host.desel();
      wb(1'b0, epd_pkg::REG_STATUS, 32'h0);
      check("no sleep", q & 32'h8, 32'h0);
      wb(1'b0, epd_pkg::REG_IRQ_STAT, 32'h0);
      check("bad code", q & 32'hc, 32'h8);
      host.send(1'b0, epd_pkg::CMD_SLEEP);
      host.send(1'b1, epd_pkg::SLEEP_CODE);
      host.desel();
      wb(1'b0, epd_pkg::REG_STATUS, 32'h0);
      check("asleep", q & 32'h8, 32'h8);
      wb(1'b0, epd_pkg::REG_IRQ_STAT, 32'h0);
      check("sleep event", q & 32'h4, 32'h4);
      host.send(1'b0, epd_pkg::CMD_REFRESH);
      host.desel();
      repeat (20) @(posedge clk_i);
      check("deaf asleep", {31'h0, busy_n}, 32'h1);
      rst_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      wb(1'b0, epd_pkg::REG_STATUS, 32'h0);
      check("awake", q & 32'h8, 32'h0);
   endtask

   task automatic t_load;
      host.send(1'b0, epd_pkg::CMD_LOAD1);
      host.send(1'b1, 8'h81);
      host.send(1'b1, 8'h3c);
      host.desel();
      host.send(1'b0, epd_pkg::CMD_LOAD2);
      host.send(1'b1, 8'h5a);
      host.desel();
      pix(14'h0000, 8'h81);
      pix(14'h0001, 8'h3c);
      pix(14'h2000, 8'h5a);
      // plane one first, so that closing plane two leaves the frame flag set
      win(epd_pkg::CMD_WIN1, 64'h0100_0000_0008_0002, 16'hc324);
      win(epd_pkg::CMD_WIN2, 64'h000f_0001_0017_0001, 16'he718);
      pix(14'h2017, 8'he7);
      pix(14'h2018, 8'h18);
      pix(14'h0020, 8'hc3);
      pix(14'h0036, 8'h24);
   endtask

   task automatic t_stop(input logic f);
      host.send(1'b0, epd_pkg::CMD_STOP);
      host.read(s);
      host.desel();
      check("stop flag", {24'h0, s & 8'h80}, {24'h0, f, 7'h00});
      check("stop refresh", {31'h0, busy_n}, {31'h0, ~f});
   endtask

   // plane two already in, so closing plane one starts the refresh itself
   task automatic t_auto;
      win(epd_pkg::CMD_WIN2, 64'h000f_0001_0017_0001, 16'he718);
      win(epd_pkg::CMD_WIN1, 64'h0100_0000_0008_0002, 16'hc324);
      check("auto refresh", {31'h0, busy_n}, 32'h0);
      check("auto drive", {30'h0, src, vcom}, 32'h3);
   endtask

   task automatic t_refresh;
      int n;
      // the refresh started by the stop command must end first
      n = 0;
      while (busy_n !== 1'b1) begin
         n++;
         if (n > 1000) tmo;
         @(posedge clk_i);
      end
      wb(1'b1, epd_pkg::REG_IRQ_STAT, 32'hf);
      wb(1'b1, epd_pkg::REG_IRQ_MASK, 32'h2);
      oe_seen <= 1'b0;
      n = 0;
      fork
         begin
            host.send(1'b0, epd_pkg::CMD_REFRESH);
            host.desel();
            host.send(1'b0, epd_pkg::CMD_STOP);
            host.desel();
         end
         begin
            while (busy_n !== 1'b0) begin
               n++;
               if (n > 1000) tmo;
               @(negedge clk_i);
            end
            check("drive on", {30'h0, src, vcom}, 32'h3);
            n = 0;
            while (busy_n === 1'b0) begin
               n++;
               if (n > 1000) tmo;
               @(negedge clk_i);
            end
            check("busy time", n, 32'd400);
         end
      join
      check("stop refused", {31'h0, oe_seen}, 32'h0);
      check("drive off", {30'h0, src, vcom}, 32'h0);
      check("irq on", {31'h0, irq}, 32'h1);
      wb(1'b1, epd_pkg::REG_IRQ_STAT, 32'h2);
      @(negedge clk_i);
      check("irq off", {31'h0, irq}, 32'h0);
   endtask

   initial begin
      rst_i = 1'b1;
      cyc = 1'b0;
      we = 1'b0;
      adr = 5'h00;
      wdat = 32'h0;
      oe_seen = 1'b0;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      t_reset;
      t_stop(1'b0);
      t_sleep;
      t_load;
      t_stop(1'b1);
      t_refresh;
      t_auto;
      finish_test;
   end
endmodule
